/* File: rtl/lfrsf_bus_if.sv */
// Interface: register port between the flag bank and its bus decoder
interface lfrsf_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       page;
  logic       hit_status;
  logic       hit_data;
  logic       hit_ctrl;
  logic       hit_irq;
  logic       wr_status;
  logic       rd_data;

  modport master (output addr, output wdata, output wr, output rd, output page,
                  input hit_status, input hit_data, input hit_ctrl, input hit_irq,
                  input wr_status, input rd_data);
  modport decoder (input addr, input wdata, input wr, input rd, input page,
                   output hit_status, output hit_data, output hit_ctrl, output hit_irq,
                   output wr_status, output rd_data);
endinterface : lfrsf_bus_if

/* File: rtl/lfrsf_decode.sv */
// Address decoder for the status flag bank register port
module lfrsf_decode
  import lfrsf_pkg::*;
(
  lfrsf_bus_if.decoder bus
);

  // ==========================================================================
  // Page-gated decode; page 1 hides the status and data registers
  assign bus.hit_status = (bus.addr == LFRSF_ADDR_STATUS) && !bus.page;
  assign bus.hit_data   = (bus.addr == LFRSF_ADDR_DATA) && !bus.page;
  assign bus.hit_ctrl   = (bus.addr == LFRSF_ADDR_CTRL);
  assign bus.hit_irq    = (bus.addr == LFRSF_ADDR_IRQ_STATUS);
  assign bus.wr_status  = bus.wr && bus.hit_status;
  assign bus.rd_data    = bus.rd && bus.hit_data;

endmodule : lfrsf_decode

/* File: rtl/lfrsf_pkg.sv */
// Package: register map, field positions, reset values and timing for the status flag bank
package lfrsf_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] LFRSF_ADDR_STATUS      = 8'h24; // Status register, page 0
  localparam logic [7:0] LFRSF_ADDR_DATA        = 8'h25; // Received byte, page 0
  localparam logic [7:0] LFRSF_ADDR_CTRL        = 8'h30; // Mode and enable bits
  localparam logic [7:0] LFRSF_ADDR_IRQ_STATUS  = 8'h31; // Interrupt request view

  // ==========================================================================
  // Status field positions
  localparam int LFRSF_BIT_DRF  = 7;
  localparam int LFRSF_BIT_ERF  = 6;
  localparam int LFRSF_BIT_CDF  = 5;
  localparam int LFRSF_BIT_IDF  = 4;
  localparam int LFRSF_BIT_OVF  = 3;
  localparam int LFRSF_BIT_EOMF = 2;
  localparam int LFRSF_BIT_LOW_POWER_SNIFF_SELECT = 1;
  localparam int LFRSF_BIT_ACK  = 0;

  // Control field positions
  localparam int LFRSF_CTL_PAGE  = 0;
  localparam int LFRSF_CTL_CARM  = 1;
  localparam int LFRSF_CTL_TOGM  = 2;
  localparam int LFRSF_CTL_DRIE  = 3;
  localparam int LFRSF_CTL_ERIE  = 4;
  localparam int LFRSF_CTL_IDIE  = 5;
  localparam int LFRSF_CTL_CDIE  = 6;
  localparam int LFRSF_CTL_CCLSB = 8;  // Validation count, 4 bits

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  LFRSF_STATUS_RST = 8'h02;
  localparam logic [11:0] LFRSF_CTRL_RST   = 12'h000;
  localparam logic [7:0]  LFRSF_DATA_RST   = 8'h00;
  localparam logic [3:0]  LFRSF_VCNT_RST   = 4'h0;

  // ==========================================================================
  // Timing: extra carrier-to-data transition delay in low power sniff
  localparam int LFRSF_CLK_MHZ      = 100;
  localparam int LFRSF_SNIFF_DLY_US = 200;
  localparam int LFRSF_SNIFF_DLY_CYC = LFRSF_SNIFF_DLY_US * LFRSF_CLK_MHZ;
  localparam logic [14:0] LFRSF_SNIFF_CNT_RST = 15'h0000;

  // Transition state machine
  typedef enum logic [2:0] {
    LFRSF_ST_CARRIER = 3'b001,
    LFRSF_ST_WAKE    = 3'b010,
    LFRSF_ST_DATA    = 3'b100
  } lfrsf_mode_t;

endpackage : lfrsf_pkg

/* File: rtl/lfrsf_top.sv */
// Status flag bank of the low-frequency wake-up receiver, with register port
//
// Function
// - Status register decodes at its address only while page select is zero.
// - Data-ready flag, bit 7, sets when a full byte is assembled.
// - Data-ready clears on data register read, acknowledge write or reset.
// - Receive-error flag, bit 6, sets on bad Manchester timing in data mode.
// - Bits received before an error are kept in the data buffer.
// - Enabled data-ready, error and ID flags request a CPU interrupt.
// - Carrier mode holds error, overrun and end-of-message flags at zero.
// - Carrier-detect flag, bit 5, sets when validation count is reached.
// - Validation counting is inactive while toggle mode is one.
// - ID-match flag, bit 4, sets on identifier match in data mode.
// - ID match flags and interrupts even with no data bits following.
// - Overrun flag, bit 3, sets when a new byte overwrites an unread one.
// - Overrun raises no interrupt of its own.
// - End-of-message flag, bit 2, sets on violation after a full byte.
// - End-of-message flag never requests an interrupt.
// - Bit 1 selects low power sniff, slower by 200 us; resets to one.
// - Writing one to acknowledge bit 0 clears all six flags.
// - Acknowledge self-clears next edge and always reads zero.
// - Writing zero to acknowledge does nothing; reset leaves it unchanged.
// - Reset clears six flags; reset value has only sniff bit set.
// - Interrupt request ignores the CPU global mask.
// - Carrier mode select zero means data mode, else carrier detect mode.
//
// Chosen here: the plain strobed port.
module lfrsf_top
  import lfrsf_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Receiver events, one-cycle pulses
  input  wire logic       ev_byte_done,
  input  wire logic [7:0] ev_byte,
  input  wire logic       ev_bit_error,
  input  wire logic [7:0] ev_partial_byte,
  input  wire logic       ev_id_match,
  input  wire logic       ev_eom_violation,
  input  wire logic       ev_carrier_valid,
  input  wire logic       ev_carrier_invalid,
  input  wire logic       ev_carrier_to_data,
  // Outputs to CPU and receiver
  output logic            irq_req,
  output logic            data_mode_ready,
  output logic            low_power_sniff_select,
  output logic            carrier_mode_select
);

  // ==========================================================================
  // Storage
  logic [7:0]  status_r,   status_nxt;
  logic [11:0] ctrl_r,     ctrl_nxt;
  logic [7:0]  data_r,     data_nxt;
  logic        unread_r,   unread_nxt;
  logic [3:0]  vcnt_r,     vcnt_nxt;
  logic [14:0] wake_cnt_r, wake_cnt_nxt;
  lfrsf_mode_t mode_r,     mode_nxt;
  logic [7:0]  rdata_r,    rdata_nxt;
  logic        irq_r,      irq_nxt;
  logic        ready_r,    ready_nxt;

  // ==========================================================================
  // Bus decode
  lfrsf_bus_if bus ();

  assign bus.addr  = reg_addr;
  assign bus.wdata = reg_wdata;
  assign bus.wr    = reg_wr;
  assign bus.rd    = reg_rd;
  assign bus.page  = ctrl_r[LFRSF_CTL_PAGE];

  lfrsf_decode u_decode (
    .bus (bus)
  );

  // ==========================================================================
  // Mode and qualifiers
  wire data_mode   = !ctrl_r[LFRSF_CTL_CARM];
  wire toggle_mode = ctrl_r[LFRSF_CTL_TOGM];
  wire [3:0] vcnt_target = ctrl_r[LFRSF_CTL_CCLSB +: 4];

  // Acknowledge is a pulse, never stored, so it always reads zero
  wire ack_wr = bus.wr_status && reg_wdata[LFRSF_BIT_ACK];

  // Validation count reached; target 0 treated as one validation
  function automatic logic count_hit(input logic [3:0] cnt, input logic [3:0] tgt);
    count_hit = ({1'b0, cnt} + 5'h01) >= ((tgt == 4'h0) ? 5'h01 : {1'b0, tgt});
  endfunction : count_hit

  wire cnt_active = !data_mode && !toggle_mode;
  wire cd_event   = cnt_active && ev_carrier_valid && count_hit(vcnt_r, vcnt_target);

  // Data-mode events; carrier mode blocks them entirely
  wire drf_set  = data_mode && (ev_byte_done || ev_bit_error && ev_partial_byte != 8'h00);
  wire erf_set  = data_mode && ev_bit_error;
  wire idf_set  = data_mode && ev_id_match;
  wire ovf_set  = data_mode && ev_byte_done && unread_r;
  wire eomf_set = data_mode && ev_eom_violation && unread_r;

  // ==========================================================================
  // Validation counter
  always_comb begin
    vcnt_nxt = vcnt_r;
    if (!cnt_active || ev_carrier_invalid) begin
      vcnt_nxt = LFRSF_VCNT_RST;
    end else if (ev_carrier_valid) begin
      vcnt_nxt = cd_event ? LFRSF_VCNT_RST : vcnt_r + 4'h1;
    end
  end

  // ==========================================================================
  // Status flags: set wins over acknowledge and data read
  always_comb begin
    status_nxt = status_r;
    if (ack_wr) begin
      status_nxt[7:2] = 6'h00;
    end
    if (bus.rd_data) begin
      status_nxt[LFRSF_BIT_DRF] = 1'b0;
    end
    if (bus.wr_status) begin
      status_nxt[LFRSF_BIT_LOW_POWER_SNIFF_SELECT] = reg_wdata[LFRSF_BIT_LOW_POWER_SNIFF_SELECT];
    end
    if (drf_set) begin
      status_nxt[LFRSF_BIT_DRF] = 1'b1;
    end
    if (erf_set) begin
      status_nxt[LFRSF_BIT_ERF] = 1'b1;
    end
    if (cd_event) begin
      status_nxt[LFRSF_BIT_CDF] = 1'b1;
    end
    if (idf_set) begin
      status_nxt[LFRSF_BIT_IDF] = 1'b1;
    end
    if (ovf_set) begin
      status_nxt[LFRSF_BIT_OVF] = 1'b1;
    end
    if (eomf_set) begin
      status_nxt[LFRSF_BIT_EOMF] = 1'b1;
    end
    if (!data_mode) begin
      status_nxt[LFRSF_BIT_ERF]  = 1'b0;
      status_nxt[LFRSF_BIT_OVF]  = 1'b0;
      status_nxt[LFRSF_BIT_EOMF] = 1'b0;
    end
    status_nxt[LFRSF_BIT_ACK] = 1'b0;
  end

  // ==========================================================================
  // Received byte buffer; partial bits before an error are kept
  always_comb begin
    data_nxt   = data_r;
    unread_nxt = unread_r;
    if (bus.rd_data) begin
      unread_nxt = 1'b0;
    end
    if (data_mode && ev_byte_done) begin
      data_nxt   = ev_byte;
      unread_nxt = 1'b1;
    end else if (erf_set && ev_partial_byte != 8'h00) begin
      data_nxt   = ev_partial_byte;
      unread_nxt = 1'b1;
    end
  end

  // ==========================================================================
  // Control register: page, modes, enables, validation count
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr && bus.hit_ctrl) begin
      ctrl_nxt[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == LFRSF_ADDR_CTRL + 8'h02) begin
      ctrl_nxt[11:8] = reg_wdata[3:0];
    end
  end

  // ==========================================================================
  // Interrupt request: overrun and end-of-message have no enable
  wire irq_drf = status_nxt[LFRSF_BIT_DRF] && ctrl_nxt[LFRSF_CTL_DRIE];
  wire irq_erf = status_nxt[LFRSF_BIT_ERF] && ctrl_nxt[LFRSF_CTL_ERIE];
  wire irq_idf = status_nxt[LFRSF_BIT_IDF] && ctrl_nxt[LFRSF_CTL_IDIE];
  wire irq_cdf = status_nxt[LFRSF_BIT_CDF] && ctrl_nxt[LFRSF_CTL_CDIE];
  // No global mask term exists here, so the CPU mask cannot hide it
  assign irq_nxt = irq_drf || irq_erf || irq_idf || irq_cdf;

  // ==========================================================================
  // Carrier-to-data transition, delayed in low power sniff
  always_comb begin
    mode_nxt     = mode_r;
    wake_cnt_nxt = wake_cnt_r;
    ready_nxt    = 1'b0;
    case (mode_r)
      LFRSF_ST_CARRIER: begin
        if (ev_carrier_to_data) begin
          if (status_r[LFRSF_BIT_LOW_POWER_SNIFF_SELECT]) begin
            mode_nxt     = LFRSF_ST_WAKE;
            wake_cnt_nxt = LFRSF_SNIFF_DLY_CYC[14:0] - 15'h0001;
          end else begin
            mode_nxt  = LFRSF_ST_DATA;
            ready_nxt = 1'b1;
          end
        end
      end
      LFRSF_ST_WAKE: begin
        if (wake_cnt_r == 15'h0000) begin
          mode_nxt  = LFRSF_ST_DATA;
          ready_nxt = 1'b1;
        end else begin
          wake_cnt_nxt = wake_cnt_r - 15'h0001;
        end
      end
      LFRSF_ST_DATA: begin
        ready_nxt = 1'b1;
        if (!ev_carrier_to_data && !data_mode) begin
          mode_nxt  = LFRSF_ST_CARRIER;
          ready_nxt = 1'b0;
        end
      end
      default: begin
        mode_nxt = LFRSF_ST_CARRIER;
      end
    endcase
  end

  // ==========================================================================
  // Read mux; unmapped or page-hidden addresses return zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (bus.hit_status) begin
        rdata_nxt = {status_r[7:1], 1'b0};
      end else if (bus.hit_data) begin
        rdata_nxt = data_r;
      end else if (bus.hit_ctrl) begin
        rdata_nxt = ctrl_r[7:0];
      end else if (reg_addr == LFRSF_ADDR_CTRL + 8'h02) begin
        rdata_nxt = {4'h0, ctrl_r[11:8]};
      end else if (bus.hit_irq) begin
        rdata_nxt = {7'h00, irq_r};
      end
    end
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_r   <= LFRSF_STATUS_RST;
      ctrl_r     <= LFRSF_CTRL_RST;
      data_r     <= LFRSF_DATA_RST;
      unread_r   <= 1'b0;
      vcnt_r     <= LFRSF_VCNT_RST;
      wake_cnt_r <= LFRSF_SNIFF_CNT_RST;
      mode_r     <= LFRSF_ST_CARRIER;
    end else begin
      status_r   <= status_nxt;
      ctrl_r     <= ctrl_nxt;
      data_r     <= data_nxt;
      unread_r   <= unread_nxt;
      vcnt_r     <= vcnt_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      mode_r     <= mode_nxt;
    end
  end

  // Output registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_r   <= irq_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign reg_rdata              = rdata_r;
  assign irq_req                = irq_r;
  assign data_mode_ready        = ready_r;
  assign low_power_sniff_select = status_r[LFRSF_BIT_LOW_POWER_SNIFF_SELECT];
  assign carrier_mode_select    = ctrl_r[LFRSF_CTL_CARM];

endmodule : lfrsf_top

/* File: test/lfrsf_bench.sv */
// Testbench: register-level tests of the status flag bank
module lfrsf_bench
  import lfrsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and event slots (0 byte, 1 error, 2 id, 3 eom, 4 valid, 5 invalid, 6 to data)
  localparam logic [7:0] VCNT = 8'h32;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [7:0] ev_data = 8'h00;
  logic       reg_wr, reg_rd, irq_req, ready;
  logic [6:0] ev = 7'h00;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         cyc = 0;
  int         irq_ev[3] = '{0, 1, 2};
  logic [7:0] irq_en[3] = '{8'h08, 8'h10, 8'h20};

  lfrsf_top u_lfrsf_top (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_byte_done(ev[0]), .ev_byte(ev_data), .ev_bit_error(ev[1]), .ev_partial_byte(ev_data),
    .ev_id_match(ev[2]), .ev_eom_violation(ev[3]), .ev_carrier_valid(ev[4]),
    .ev_carrier_invalid(ev[5]), .ev_carrier_to_data(ev[6]), .irq_req(irq_req),
    .data_mode_ready(ready), .low_power_sniff_select(), .carrier_mode_select());
  lfrsf_cpu_model u_lfrsf_cpu_model (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ==========================================================================
  // Clock and hang guard; the slow sniff wake-up dominates, about 20200 cycles in all
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_lfrsf_cpu_model.rd(a, rv);
    chk(rv, exp);
  endtask : rchk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_lfrsf_cpu_model.wr(a, d);
  endtask : wr
  // Receiver events are one-cycle pulses
  task automatic pulse(input int k, input logic [7:0] d);
    @(posedge clock);
    ev      <= 7'h01 << k;
    ev_data <= d;
    @(posedge clock);
    ev      <= 7'h00;
  endtask : pulse
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rchk(LFRSF_ADDR_STATUS, 8'h02);
    wr(LFRSF_ADDR_STATUS, 8'hFC);
    rchk(LFRSF_ADDR_STATUS, 8'h00);
    wr(LFRSF_ADDR_STATUS, 8'h02);
    rchk(LFRSF_ADDR_STATUS, 8'h02);
    $display("test reset done");
    pulse(0, 8'hA5);
    rchk(LFRSF_ADDR_STATUS, 8'h82);
    pulse(0, 8'h3C);
    rchk(LFRSF_ADDR_STATUS, 8'h8A);
    rchk(LFRSF_ADDR_DATA, 8'h3C);
    rchk(LFRSF_ADDR_STATUS, 8'h0A);
    pulse(0, 8'h11);
    pulse(3, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h8E);
    wr(LFRSF_ADDR_STATUS, 8'h03);
    rchk(LFRSF_ADDR_STATUS, 8'h02);
    pulse(1, 8'h05);
    rchk(LFRSF_ADDR_STATUS, 8'hC2);
    rchk(LFRSF_ADDR_DATA, 8'h05);
    pulse(2, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h52);
    wr(LFRSF_ADDR_STATUS, 8'h03);
    rchk(LFRSF_ADDR_STATUS, 8'h02);
    $display("test flags done");
    foreach (irq_en[i]) begin
      wr(LFRSF_ADDR_STATUS, 8'h03);
      wr(LFRSF_ADDR_CTRL, irq_en[i]);
      rchk(LFRSF_ADDR_IRQ_STATUS, 8'h00);
      pulse(irq_ev[i], 8'h5A);
      rchk(LFRSF_ADDR_IRQ_STATUS, 8'h01);
      chk({7'h00, irq_req}, 8'h01);
    end
    wr(LFRSF_ADDR_STATUS, 8'h03);
    rchk(LFRSF_ADDR_IRQ_STATUS, 8'h00);
    wr(LFRSF_ADDR_CTRL, 8'h30);
    pulse(0, 8'h01);
    pulse(0, 8'h02);
    pulse(3, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h8E);
    rchk(LFRSF_ADDR_IRQ_STATUS, 8'h00);
    $display("test interrupt done");
    wr(LFRSF_ADDR_CTRL, 8'h01);
    rchk(LFRSF_ADDR_STATUS, 8'h00);
    wr(LFRSF_ADDR_CTRL, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h8E);
    $display("test page done");
    wr(LFRSF_ADDR_STATUS, 8'h03);
    wr(LFRSF_ADDR_CTRL, 8'h02);
    wr(VCNT, 8'h03);
    pulse(4, 8'h00);
    pulse(5, 8'h00);
    repeat (2) pulse(4, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h02);
    pulse(4, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h22);
    pulse(1, 8'h00);
    pulse(3, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h22);
    wr(LFRSF_ADDR_STATUS, 8'h03);
    wr(LFRSF_ADDR_CTRL, 8'h06);
    repeat (3) pulse(4, 8'h00);
    rchk(LFRSF_ADDR_STATUS, 8'h02);
    $display("test carrier done");
    // Fast switch with sniff bit low, then the slow one with it high
    wr(LFRSF_ADDR_STATUS, 8'h00);
    wr(LFRSF_ADDR_CTRL, 8'h00);
    pulse(6, 8'h00);
    @(posedge clock);
    chk({7'h00, ready}, 8'h01);
    wr(LFRSF_ADDR_CTRL, 8'h02);
    wr(LFRSF_ADDR_STATUS, 8'h02);
    wr(LFRSF_ADDR_CTRL, 8'h00);
    pulse(6, 8'h00);
    repeat (LFRSF_SNIFF_DLY_CYC - 1) @(posedge clock);
    chk({7'h00, ready}, 8'h00);
    repeat (2) @(posedge clock);
    chk({7'h00, ready}, 8'h01);
    $display("test sniff done");
    stop_test();
  end
endmodule : lfrsf_bench

/* File: test/lfrsf_cpu_model.sv */
// Partner model: CPU side of the register port with single-cycle strobes
module lfrsf_cpu_model
  import lfrsf_pkg::*;
(
  // Clock
  input  wire logic       clock,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One-cycle write; the slave never stalls, so the strobe drops after one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // One-cycle read; data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask : rd
endmodule : lfrsf_cpu_model

/* File: test/lfrsf_props.sv */
// Checker: concurrent assertions on the status flag bank ports
module lfrsf_props
  import lfrsf_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Receiver events
  input wire logic       ev_byte_done,
  input wire logic       ev_bit_error,
  input wire logic       ev_id_match,
  input wire logic       ev_eom_violation,
  input wire logic       ev_carrier_valid,
  // Outputs
  input wire logic       irq_req,
  input wire logic       low_power_sniff_select,
  input wire logic       carrier_mode_select
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Shadow of the control register, so paging and enables are seen from the port
  logic [7:0] ctrl_r;
  always_ff @(posedge clock) begin
    if (!rst_n) ctrl_r <= 8'h00;
    else if (reg_wr && reg_addr == LFRSF_ADDR_CTRL) ctrl_r <= reg_wdata;
  end
  wire logic st_rd = reg_rd && reg_addr == LFRSF_ADDR_STATUS && !ctrl_r[LFRSF_CTL_PAGE];
  wire logic st_wr = reg_wr && reg_addr == LFRSF_ADDR_STATUS && !ctrl_r[LFRSF_CTL_PAGE];
  wire logic dt_rd = reg_rd && reg_addr == LFRSF_ADDR_DATA && !ctrl_r[LFRSF_CTL_PAGE];
  // A carrier validation may legally set the carrier-detect flag, so it breaks quiet too
  wire logic quiet = !ev_byte_done && !ev_bit_error && !ev_id_match && !ev_eom_violation &&
                     !ev_carrier_valid;
  wire logic ct_wr = reg_wr && reg_addr == LFRSF_ADDR_CTRL;
  // Any event in the gap would legally set a flag again, so the gap must be quiet
  wire logic irq_src = (ev_byte_done && ctrl_r[LFRSF_CTL_DRIE]) ||
                       (ev_bit_error && ctrl_r[LFRSF_CTL_ERIE]) ||
                       (ev_id_match && ctrl_r[LFRSF_CTL_IDIE]);

  // ==========================================================================
  // Multi-step accesses: acknowledge then status read, data read then status read
  sequence s_ack;
    st_wr && reg_wdata[LFRSF_BIT_ACK] && quiet ##1 quiet ##1 st_rd && quiet;
  endsequence
  sequence s_drd;
    dt_rd && quiet ##1 quiet [*2] ##1 st_rd && quiet;
  endsequence

  // ==========================================================================
  // Properties
  AST_RST_STATE: assert property (disable iff (1'b0) !rst_n |=>
    low_power_sniff_select && !irq_req && reg_rdata == 8'h00) else $error("reset state wrong");
  AST_ACK_CLEARS: assert property (s_ack |=> reg_rdata[7:2] == 6'h00)
    else $error("flags not cleared by acknowledge");
  AST_DATA_READ: assert property (s_drd |=> !reg_rdata[LFRSF_BIT_DRF])
    else $error("data ready not cleared by data read");
  AST_ACK_READS_ZERO: assert property (reg_rd && reg_addr == LFRSF_ADDR_STATUS |=>
    !reg_rdata[LFRSF_BIT_ACK]) else $error("acknowledge bit read as one");
  AST_PAGE_HIDE: assert property (reg_rd && reg_addr == LFRSF_ADDR_STATUS &&
    ctrl_r[LFRSF_CTL_PAGE] |=> reg_rdata == 8'h00) else $error("status visible on page one");
  AST_SNIFF_READ: assert property (st_rd |=>
    reg_rdata[LFRSF_BIT_LOW_POWER_SNIFF_SELECT] == $past(low_power_sniff_select)) else $error("sniff bit mismatch");
  AST_SNIFF_WR: assert property (st_wr |=>
    low_power_sniff_select == $past(reg_wdata[LFRSF_BIT_LOW_POWER_SNIFF_SELECT])) else $error("sniff bit not written");
  AST_MODE_SEL: assert property (ct_wr |=>
    carrier_mode_select == $past(reg_wdata[LFRSF_CTL_CARM])) else $error("mode select wrong");
  AST_IRQ_SET: assert property (irq_src && !ctrl_r[LFRSF_CTL_CARM] && !ct_wr |=> irq_req)
    else $error("enabled flag gave no interrupt");
  AST_IRQ_OFF: assert property (ctrl_r[6:3] == 4'h0 ##1 ctrl_r[6:3] == 4'h0 |-> !irq_req)
    else $error("interrupt with all enables off");
  AST_CARRIER_QUIET: assert property ($past(ctrl_r[LFRSF_CTL_CARM]) && ctrl_r[LFRSF_CTL_CARM]
    && st_rd |=> reg_rdata[6] == 1'b0 && reg_rdata[3:2] == 2'b00) else $error("data flag in carrier mode");
endmodule : lfrsf_props

bind lfrsf_top lfrsf_props u_lfrsf_props (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ev_byte_done(ev_byte_done), .ev_bit_error(ev_bit_error), .ev_id_match(ev_id_match),
  .ev_eom_violation(ev_eom_violation), .ev_carrier_valid(ev_carrier_valid), .irq_req(irq_req),
  .low_power_sniff_select(low_power_sniff_select), .carrier_mode_select(carrier_mode_select));
